/* File: dma_channel_descriptor_logic.sv */
// Descriptor fetch, decode and transfer sequencing for the DMA channels
// What this block does
// - Every channel owns a primary and an alternate structure, placed apart.
// - Simple modes take parameters from one structure only.
// - Ping-pong and scatter-gather modes use both structures of a channel.
// - A structure is four words; the fourth is reserved and never read.
// - Word at offset 0x00 is the source end pointer.
// - Word at offset 0x04 is the destination end pointer.
// - Word at offset 0x08 is the channel control word.
// - Sizes, transfer count and arbitration count come from the structure.
// - Primary at channel times 16 from 0x000, alternate from 0x200.
// - Descriptor word address is base pointer plus relative offset.
// - Every transfer takes its control from the control word.
// - Bits 31:30 pick destination increment; narrower than data is reserved.
// - Destination code 11 keeps the address at the destination end pointer.
// - Bits 29:28 give destination width, which must equal source width.
// - Bits 27:26 pick source increment; code 11 holds the source address.
// - After the programmed transfers the channel's completion pulse fires.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module dma_channel_descriptor_logic #(
    parameter int NUM_CH = dma_desc_pkg::NUM_CHANNELS,
    parameter int CNT_W = dma_desc_pkg::COUNT_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [dma_desc_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic start_valid,
    input wire logic [dma_desc_pkg::CHAN_W-1:0] start_chan,
    input wire logic start_alt,
    output logic busy,
    output logic mem_rd,
    output logic [31:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic xfer_req,
    output logic [31:0] xfer_src_addr,
    output logic [31:0] xfer_dst_addr,
    output logic [1:0] xfer_width,
    output logic [dma_desc_pkg::ARB_W-1:0] xfer_arb_power,
    input wire logic xfer_ack,
    output logic [NUM_CH-1:0] done_irq,
    output logic err_flag
);
    import dma_desc_pkg::*;

    // =========================================================
    // State
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_WAIT = 3'b011,
        S_DECODE = 3'b010,
        S_ISSUE = 3'b110,
        S_XWAIT = 3'b111,
        S_DONE = 3'b101
    } state_t;

    typedef struct packed {
        state_t st;
        logic en;
        logic [31:0] base;
        logic [CHAN_W-1:0] ch;
        logic alt;
        logic second;
        logic [1:0] word;
        logic [31:0] src_end;
        logic [31:0] dst_end;
        logic [31:0] ctrl;
        logic [CNT_W-1:0] left;
        logic [3:0] err;
        logic err_flag;
        logic busy;
        logic mem_rd;
        logic [31:0] mem_addr;
        logic xfer_req;
        logic [31:0] xs;
        logic [31:0] xd;
        logic [31:0] rdata;
        logic [NUM_CH-1:0] irq;
    } regs_t;

    regs_t q;
    regs_t d;

    // =========================================================
    // Field decode
    width_inc_if src_f();
    width_inc_if dst_f();

    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [1:0] src_width;
    logic [1:0] dst_width;
    xfer_mode_t mode;
    logic complex_mode;
    logic any_bad;
    logic [3:0] bad_code;

    assign src_width = q.ctrl[SRC_WIDTH_LSB +: 2];
    assign dst_width = q.ctrl[DST_WIDTH_LSB +: 2];
    assign mode = xfer_mode_t'(q.ctrl[MODE_LSB +: 3]);
    // Ping-pong and all gather modes sit at codes three and up
    assign complex_mode = (q.ctrl[MODE_LSB +: 3] >= MODE_PINGPONG);
    assign src_f.width_code = src_width;
    assign src_f.inc_code = q.ctrl[SOURCE_INC_LSB +: 2];
    // Destination step is judged against the source width
    assign dst_f.width_code = src_width;
    assign dst_f.inc_code = q.ctrl[DEST_INC_LSB +: 2];

    inc_decode u_src_dec (
        .f(src_f)
    );

    inc_decode u_dst_dec (
        .f(dst_f)
    );

    addr_step_calc #(.CNT_W(CNT_W)) u_src_addr (
        .f(src_f),
        .end_ptr(q.src_end),
        .remaining(q.left),
        .addr(src_addr)
    );

    addr_step_calc #(.CNT_W(CNT_W)) u_dst_addr (
        .f(dst_f),
        .end_ptr(q.dst_end),
        .remaining(q.left),
        .addr(dst_addr)
    );

    always_comb begin
        bad_code = ERR_NONE;
        if (mode == MODE_STOP) begin
            bad_code = ERR_STOP_MODE;
        end else if (src_f.bad) begin
            bad_code = ERR_SRC_CODE;
        end else if (dst_f.bad) begin
            bad_code = ERR_DST_CODE;
        end else if (dst_width != src_width) begin
            bad_code = ERR_WIDTH_MISMATCH;
        end
        any_bad = (bad_code != ERR_NONE);
    end

    // =========================================================
    // Descriptor addressing
    function automatic logic [31:0] struct_offset(
        input logic [CHAN_W-1:0] ch,
        input logic alt
    );
        logic [31:0] area;
        area = alt ? ALTERNATE_BASE : PRIMARY_BASE;
        return area + (32'(ch) << STRUCT_SHIFT);
    endfunction : struct_offset

    function automatic logic [31:0] word_offset(input logic [1:0] w);
        logic [3:0] ofs;
        case (w)
            WORD_SRC: ofs = OFS_SRC_END;
            WORD_DST: ofs = OFS_DST_END;
            default: ofs = OFS_CTRL;
        endcase
        return 32'(ofs);
    endfunction : word_offset

    // =========================================================
    // Next state
    always_comb begin
        d = q;
        d.irq = '0;
        d.mem_rd = 1'b0;
        d.rdata = '0;

        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: d.en = reg_wdata[CTRL_EN_BIT];
                REG_BASE: d.base = reg_wdata;
                REG_STATUS: begin
                    if (reg_wdata[STAT_ERR_BIT]) begin
                        d.err_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: d.rdata = 32'(q.en);
                REG_BASE: d.rdata = q.base;
                REG_STATUS: begin
                    d.rdata[STAT_BUSY_BIT] = q.busy;
                    d.rdata[STAT_ERR_BIT] = q.err_flag;
                    d.rdata[STAT_CODE_LSB +: 4] = q.err;
                end
                REG_LAST_CTRL: d.rdata = q.ctrl;
                default: d.rdata = '0;
            endcase
        end

        case (q.st)
            S_IDLE: begin
                if (start_valid && q.en) begin
                    d.ch = start_chan;
                    d.alt = start_alt;
                    d.second = 1'b0;
                    d.word = WORD_SRC;
                    d.st = S_FETCH;
                end
            end
            S_FETCH: begin
                d.mem_rd = 1'b1;
                d.mem_addr = q.base + struct_offset(q.ch, q.alt)
                           + word_offset(q.word);
                d.st = S_WAIT;
            end
            S_WAIT: begin
                if (mem_rvalid) begin
                    case (q.word)
                        WORD_SRC: d.src_end = mem_rdata;
                        WORD_DST: d.dst_end = mem_rdata;
                        default: d.ctrl = mem_rdata;
                    endcase
                    // Reserved fourth word is skipped
                    if (q.word == WORD_CTRL) begin
                        d.st = S_DECODE;
                    end else begin
                        d.word = q.word + 2'h1;
                        d.st = S_FETCH;
                    end
                end
            end
            S_DECODE: begin
                if (any_bad) begin
                    d.err = bad_code;
                    d.err_flag = 1'b1;
                    d.st = S_IDLE;
                end else begin
                    d.err = ERR_NONE;
                    d.left = q.ctrl[NM1_LSB +: CNT_W];
                    d.st = S_ISSUE;
                end
            end
            S_ISSUE: begin
                d.xfer_req = 1'b1;
                d.xs = src_addr;
                d.xd = dst_addr;
                d.st = S_XWAIT;
            end
            S_XWAIT: begin
                if (xfer_ack) begin
                    d.xfer_req = 1'b0;
                    if (q.left == '0) begin
                        d.st = S_DONE;
                    end else begin
                        d.left = q.left - 1'b1;
                        d.st = S_ISSUE;
                    end
                end
            end
            S_DONE: begin
                if (complex_mode && !q.second) begin
                    d.second = 1'b1;
                    d.alt = !q.alt;
                    d.word = WORD_SRC;
                    d.st = S_FETCH;
                end else begin
                    d.irq[q.ch] = 1'b1;
                    d.st = S_IDLE;
                end
            end
            default: d.st = S_IDLE;
        endcase

        d.busy = (d.st != S_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= S_IDLE;
            q.en <= CTRL_EN_RST;
            q.base <= BASE_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign busy = q.busy;
    assign mem_rd = q.mem_rd;
    assign mem_addr = q.mem_addr;
    assign xfer_req = q.xfer_req;
    assign xfer_src_addr = q.xs;
    assign xfer_dst_addr = q.xd;
    assign xfer_width = q.ctrl[SRC_WIDTH_LSB +: 2];
    assign xfer_arb_power = q.ctrl[ARB_LSB +: ARB_W];
    assign done_irq = q.irq;
    assign err_flag = q.err_flag;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    logic [31:0] rel_addr;
    assign rel_addr = q.mem_addr - q.base;

    property p_struct_place;
        q.mem_rd |-> rel_addr[9:4] == {q.alt, q.ch};
    endproperty
    a_struct_place: assert property (p_struct_place)
        else $error("descriptor read outside channel structure");

    property p_no_reserved;
        q.mem_rd |-> rel_addr[3:0] != OFS_RSVD && rel_addr[31:10] == '0;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("reserved word or address off base fetched");

    property p_src_word;
        (q.st == S_WAIT && mem_rvalid && q.word == WORD_SRC)
            |=> q.src_end == $past(mem_rdata) && q.st == S_FETCH;
    endproperty
    a_src_word: assert property (p_src_word)
        else $error("source end pointer not captured");

    property p_ctrl_word;
        (q.st == S_WAIT && mem_rvalid && q.word == WORD_CTRL)
            |=> q.ctrl == $past(mem_rdata) ##1 q.st != S_FETCH;
    endproperty
    a_ctrl_word: assert property (p_ctrl_word)
        else $error("control word not captured");

    property p_bad_stops;
        (q.st == S_DECODE && any_bad) |=> q.err_flag && !q.busy
            ##1 !q.xfer_req;
    endproperty
    a_bad_stops: assert property (p_bad_stops)
        else $error("reserved code did not stop the channel");

    property p_fixed_dst;
        (q.xfer_req && dst_f.fixed) |-> q.xd == q.dst_end;
    endproperty
    a_fixed_dst: assert property (p_fixed_dst)
        else $error("fixed destination address moved");

    property p_last_at_end;
        ($rose(q.xfer_req) && q.left == '0) |-> q.xs == q.src_end;
    endproperty
    a_last_at_end: assert property (p_last_at_end)
        else $error("last source address is not the end pointer");

    property p_done_pulse;
        (q.st == S_XWAIT && xfer_ack && q.left == '0 && !complex_mode)
            |-> ##2 q.irq[q.ch] ##1 q.irq == '0;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse missing or too long");

    property p_alt_second;
        (q.st == S_DONE && complex_mode && !q.second)
            |=> q.st == S_FETCH && q.alt != $past(q.alt) && q.irq == '0;
    endproperty
    a_alt_second: assert property (p_alt_second)
        else $error("complex mode did not move to other structure");

    property p_simple_one;
        (q.st == S_DONE && !complex_mode) |=> q.st == S_IDLE;
    endproperty
    a_simple_one: assert property (p_simple_one)
        else $error("simple mode touched a second structure");

    c_basic_done: cover property (q.st == S_DONE && !complex_mode);
    c_complex: cover property (q.st == S_DONE && q.second);
    c_error: cover property (q.st == S_DECODE && any_bad);
    c_multi: cover property (q.st == S_XWAIT && xfer_ack && q.left != '0);

endmodule : dma_channel_descriptor_logic

/* File: dma_desc_pkg.sv */
// Shared constants and types for the DMA descriptor logic
package dma_desc_pkg;

    // =========================================================
    // Sizes
    localparam int NUM_CHANNELS = 31;
    localparam int CHAN_W = 5;
    localparam int COUNT_W = 10;
    localparam int ARB_W = 4;
    localparam int REG_AW = 8;

    // =========================================================
    // Descriptor layout
    localparam logic [31:0] PRIMARY_BASE = 32'h0000_0000;
    localparam logic [31:0] ALTERNATE_BASE = 32'h0000_0200;
    localparam int STRUCT_SHIFT = 4;
    localparam logic [3:0] OFS_SRC_END = 4'h0;
    localparam logic [3:0] OFS_DST_END = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_RSVD = 4'hc;
    localparam logic [1:0] WORD_SRC = 2'h0;
    localparam logic [1:0] WORD_DST = 2'h1;
    localparam logic [1:0] WORD_CTRL = 2'h2;

    // =========================================================
    // Control word fields
    localparam int DEST_INC_LSB = 30;
    localparam int DST_WIDTH_LSB = 28;
    localparam int SOURCE_INC_LSB = 26;
    localparam int SRC_WIDTH_LSB = 24;
    localparam int ARB_LSB = 14;
    localparam int NM1_LSB = 4;
    localparam int MODE_LSB = 0;
    localparam logic [1:0] CODE_FIXED = 2'h3;

    typedef enum logic [2:0] {
        MODE_STOP = 3'h0,
        MODE_BASIC = 3'h1,
        MODE_AUTO = 3'h2,
        MODE_PINGPONG = 3'h3
    } xfer_mode_t;

    // =========================================================
    // Software registers
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_BASE = 8'h04;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [REG_AW-1:0] REG_LAST_CTRL = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_CODE_LSB = 4;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        ERR_NONE = 4'h0,
        ERR_STOP_MODE = 4'h1,
        ERR_SRC_CODE = 4'h2,
        ERR_DST_CODE = 4'h3,
        ERR_WIDTH_MISMATCH = 4'h4
    } err_code_t;

endpackage : dma_desc_pkg

/* File: width_inc_if.sv */
// Width and increment codes with their decoded meaning
`timescale 1ns/1ps
interface width_inc_if;
    logic [1:0] width_code;
    logic [1:0] inc_code;
    logic fixed;
    logic bad;
    logic [1:0] step_shift;

    modport drv (output width_code, output inc_code,
                 input fixed, input bad, input step_shift);
    modport dec (input width_code, input inc_code,
                 output fixed, output bad, output step_shift);
    modport calc (input fixed, input step_shift);
endinterface : width_inc_if

/* File: inc_decode.sv */
// Decodes one increment code against the source data width
`timescale 1ns/1ps
module inc_decode (
    width_inc_if.dec f
);
    import dma_desc_pkg::*;

    always_comb begin
        f.fixed = (f.inc_code == CODE_FIXED);
        // Steps narrower than the data width are reserved
        f.bad = (f.width_code == CODE_FIXED) ||
                (!f.fixed && (f.inc_code < f.width_code));
        f.step_shift = f.fixed ? 2'h0 : f.inc_code;
    end
endmodule : inc_decode

/* File: addr_step_calc.sv */
// Current address from an end pointer and the transfers still to go
`timescale 1ns/1ps
module addr_step_calc #(
    parameter int CNT_W = dma_desc_pkg::COUNT_W
) (
    width_inc_if.calc f,
    input wire logic [31:0] end_ptr,
    input wire logic [CNT_W-1:0] remaining,
    output logic [31:0] addr
);
    logic [31:0] back;

    always_comb begin
        back = 32'(remaining) << f.step_shift;
        // End pointer is never rewritten; address is derived from it
        addr = f.fixed ? end_ptr : end_ptr - back;
    end
endmodule : addr_step_calc

/* File: dma_desc_sram_model.sv */
// Descriptor SRAM model answering word reads with a set latency
`timescale 1ns/1ps
module dma_desc_sram_model (
    input wire logic clk_sys,
    input wire logic mem_rd,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0] lat,
    output logic [31:0] mem_rdata,
    output logic mem_rvalid,
    output int rsvd_hits
);
    // Words that software placed before the start
    logic [31:0] mem [logic [31:0]];
    logic [31:0] addr_q;
    logic [1:0] cnt_q;
    logic pend_q;

    initial begin
        mem_rvalid = 1'b0;
        mem_rdata = 32'h0;
        pend_q = 1'b0;
        cnt_q = 2'h0;
        rsvd_hits = 0;
    end

    // =========================================================
    // Read answer
    always @(posedge clk_sys) begin
        mem_rvalid <= 1'b0;
        // Data not held once the answer has passed
        mem_rdata <= ~mem_rdata;
        if (mem_rd) begin
            pend_q <= 1'b1;
            cnt_q <= lat;
            addr_q <= mem_addr;
            if (mem_addr[3:0] == 4'hc) begin
                rsvd_hits <= rsvd_hits + 1;
            end
        end else if (pend_q && cnt_q == 2'h0) begin
            pend_q <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= mem.exists(addr_q) ? mem[addr_q] : 32'h0;
        end else if (pend_q) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule : dma_desc_sram_model

/* File: dma_channel_descriptor_logic_tb.sv */
// Self-checking bench for the DMA descriptor logic
`timescale 1ns/1ps
module dma_channel_descriptor_logic_tb;
    import dma_desc_pkg::*;
    typedef struct {
        logic [4:0] ch;
        logic alt;
        logic [31:0] ctrl;
        logic [3:0] err;
    } row_t;
    logic clk_sys, rstn, reg_wr, reg_rd, start_valid, start_alt;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_rdata;
    logic [4:0] start_chan;
    logic busy, mem_rd, mem_rvalid, xfer_req, xfer_ack, err_flag;
    logic [31:0] xfer_src_addr, xfer_dst_addr, d;
    logic [1:0] xfer_width, lat;
    logic [3:0] xfer_arb_power;
    logic [30:0] done_irq;
    int rsvd_hits, errors, n_tests;
    logic [31:0] rd_q [$];
    row_t rows [8];

    dma_channel_descriptor_logic dma_channel_descriptor_logic_i (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .start_valid(start_valid),
        .start_chan(start_chan), .start_alt(start_alt), .busy(busy),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .xfer_req(xfer_req),
        .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
        .xfer_width(xfer_width), .xfer_arb_power(xfer_arb_power),
        .xfer_ack(xfer_ack), .done_irq(done_irq), .err_flag(err_flag)
    );
    dma_desc_sram_model dma_desc_sram_model_i (
        .clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .rsvd_hits(rsvd_hits)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (mem_rd === 1'b1) begin
            rd_q.push_back(mem_addr);
        end
    end

    // =========================================================
    // Helpers
    task end_of_test;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : reg_read

    task automatic wait_for(input int which);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (which == 0 && xfer_req === 1'b1) break;
            if (which == 1 && err_flag === 1'b1) break;
            if (which == 2 && done_irq !== 31'h0) break;
        end
        if (i == 300) begin
            chk(32'hffff_ffff, which);
            end_of_test();
        end
    endtask : wait_for

    function automatic logic [31:0] mk(input logic [1:0] di, dw, si, sw,
        input logic [3:0] arb, input logic [9:0] nm1, input logic [2:0] md);
        return {di, dw, si, sw, 6'h00, arb, nm1, 1'b0, md};
    endfunction : mk

    function automatic logic [31:0] ea(input logic [31:0] e,
        input logic [1:0] c, input int rem);
        return (c == 2'h3) ? e : e - (32'(rem) << c);
    endfunction : ea

    // =========================================================
    // One descriptor run from the table
    task automatic run(input int r);
        row_t w;
        logic [31:0] b, a, se, de;
        int n, ns;
        w = rows[r];
        b = 32'h2000_0000 + 32'(r) * 32'h1000;
        ns = (w.ctrl[2:0] >= 3'h3) ? 2 : 1;
        n = int'(w.ctrl[13:4]) + 1;
        for (int s = 0; s < 2; s++) begin
            a = b + ((w.alt ^ s[0]) ? 32'h200 : 32'h0) + 32'(w.ch) * 32'h10;
            // Word aligned end pointers
            se = 32'h1000_0ffc + {18'h0, w.ch, s[0], 8'h00};
            dma_desc_sram_model_i.mem[a] = se;
            dma_desc_sram_model_i.mem[a + 4] = se + 32'h2000_0000;
            dma_desc_sram_model_i.mem[a + 8] = w.ctrl;
            dma_desc_sram_model_i.mem[a + 12] = 32'h5a5a_5a5a;
        end
        reg_write(REG_BASE, b);
        @(posedge clk_sys);
        start_valid <= 1'b1;
        start_chan <= w.ch;
        start_alt <= w.alt;
        lat <= 2'(r % 3);
        // Second cycle of the request falls while busy
        repeat (2) @(posedge clk_sys);
        start_valid <= 1'b0;
        for (int s = 0; s < ns; s++) begin
            a = b + ((w.alt ^ s[0]) ? 32'h200 : 32'h0) + 32'(w.ch) * 32'h10;
            se = 32'h1000_0ffc + {18'h0, w.ch, s[0], 8'h00};
            de = se + 32'h2000_0000;
            for (int k = 0; k < n && w.err == 4'h0; k++) begin
                wait_for(0);
                chk(xfer_src_addr, ea(se, w.ctrl[27:26], n - 1 - k));
                chk(xfer_dst_addr, ea(de, w.ctrl[31:30], n - 1 - k));
                chk(xfer_width, w.ctrl[25:24]);
                chk(xfer_arb_power, w.ctrl[17:14]);
                @(posedge clk_sys);
                xfer_ack <= 1'b1;
                @(posedge clk_sys);
                xfer_ack <= 1'b0;
            end
            if (w.err != 4'h0) wait_for(1);
            chk(rd_q.size(), 3);
            for (int j = 0; j < 3; j++) begin
                chk(rd_q.pop_front(), a + 32'(4 * j));
            end
        end
        if (w.err != 4'h0) begin
            chk(busy, 1'b0);
            reg_read(REG_STATUS, d);
            chk(d[7:0], {w.err, 4'h2});
            reg_write(REG_STATUS, 32'h2);
            reg_read(REG_STATUS, d);
            chk(d[1], 1'b0);
        end else begin
            wait_for(2);
            chk(done_irq, 31'h1 << w.ch);
            chk(busy, 1'b0);
        end
        reg_read(REG_LAST_CTRL, d);
        chk(d, w.ctrl);
    endtask : run

    // =========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        {reg_wr, reg_rd, start_valid, start_alt, xfer_ack} = 5'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        start_chan = 5'h0;
        lat = 2'h0;
        errors = 0;
        n_tests = 0;
        rows[0] = '{5'd0, 1'b0, mk(0, 0, 0, 0, 2, 2, 1), 4'h0};
        rows[1] = '{5'd30, 1'b1, mk(1, 1, 3, 1, 5, 1, 2), 4'h0};
        rows[2] = '{5'd1, 1'b0, mk(3, 2, 2, 2, 15, 3, 1), 4'h0};
        rows[3] = '{5'd5, 1'b0, mk(2, 2, 2, 2, 1, 1, 3), 4'h0};
        rows[4] = '{5'd2, 1'b0, mk(0, 1, 1, 1, 0, 0, 1), 4'h3};
        rows[5] = '{5'd3, 1'b1, mk(2, 2, 1, 2, 0, 0, 1), 4'h2};
        rows[6] = '{5'd4, 1'b0, mk(0, 0, 0, 0, 0, 0, 0), 4'h1};
        rows[7] = '{5'd6, 1'b0, mk(1, 1, 0, 0, 0, 0, 1), 4'h4};
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_read(REG_CTRL, d);
        chk(d, 32'h0);
        reg_read(REG_BASE, d);
        chk(d, BASE_RST);
        // Start while disabled is dropped
        @(posedge clk_sys);
        start_valid <= 1'b1;
        @(posedge clk_sys);
        start_valid <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(rd_q.size(), 0);
        reg_write(REG_CTRL, 32'h1);
        reg_read(8'h40, d);
        chk(d, 32'h0);
        for (int r = 0; r < 8; r++) begin
            run(r);
        end
        chk(rsvd_hits, 0);
        // Reset in the middle of a descriptor fetch
        @(posedge clk_sys);
        start_valid <= 1'b1;
        repeat (4) @(posedge clk_sys);
        start_valid <= 1'b0;
        rstn <= 1'b0;
        @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        chk({busy, mem_rd, xfer_req, err_flag}, 4'h0);
        reg_read(REG_CTRL, d);
        chk(d, 32'h0);
        end_of_test();
    end
endmodule : dma_channel_descriptor_logic_tb
